// ### design/dac_serial_consts.vh
// Constants for the serial DAC command interface
`ifndef DAC_SERIAL_CONSTS_VH
`define DAC_SERIAL_CONSTS_VH

// ****************************************
// Word layout
// ****************************************
`define SHIFT_WIDTH    32
`define DATA_WIDTH     16
`define CMD_WIDTH      4
`define CMD_MSB        23
`define CMD_LSB        20
`define DATA_MSB       15
`define DATA_LSB       0

// ****************************************
// Command codes
// ****************************************
`define CMD_WRITE      4'h0
`define CMD_UPDATE     4'h1
`define CMD_WRITE_UPD  4'h3
`define CMD_POWER_DOWN 4'h4
`define CMD_NOP        4'hF

// ****************************************
// Reset values
// ****************************************
`define CODE_ZERO      16'h0000
`define CODE_MID       16'h8000

`endif

// ### design/dac_serial_if.v
// Serial command interface of a single-channel voltage-output DAC
`timescale 1ns/1ps
`include "dac_serial_consts.vh"
module dac_serial_if #(
  parameter MIDSCALE_RESET = 0
) (
  // System
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        clk_en,
  // Serial link pins
  input  wire        serial_clk,
  input  wire        select_load_n,
  input  wire        serial_in,
  output reg         serial_out,
  // Control pins
  input  wire        async_update_n,
  input  wire        async_clear_n,
  // Converter side
  output reg  [15:0] dac_code,
  output reg  [15:0] input_code,
  output reg         powered_down
);

  // ****************************************
  // Reset value
  // ****************************************
  // Reset and the clear pin both load the variant's code
  localparam [15:0] RESET_CODE = (MIDSCALE_RESET != 0) ? `CODE_MID : `CODE_ZERO;

  // ****************************************
  // Command decode
  // ****************************************
  function cmd_writes;
    input [3:0] code;
    begin
      cmd_writes = (code == `CMD_WRITE) || (code == `CMD_WRITE_UPD);
    end
  endfunction

  function cmd_updates;
    input [3:0] code;
    begin
      cmd_updates = (code == `CMD_UPDATE) || (code == `CMD_WRITE_UPD);
    end
  endfunction

  function cmd_sleeps;
    input [3:0] code;
    begin
      cmd_sleeps = (code == `CMD_POWER_DOWN);
    end
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  reg [1:0] sclk_s_q;
  reg [1:0] sel_s_q;
  reg [1:0] sdi_s_q;
  reg [1:0] upd_s_q;
  reg [1:0] clr_s_q;

  // Serial clock, idles low
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sclk_s_q <= 2'h0;
    end
    else if (clk_en)
    begin
      sclk_s_q <= {sclk_s_q[0], serial_clk};
    end
  end

  // Select, idles high
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sel_s_q <= 2'h3;
    end
    else if (clk_en)
    begin
      sel_s_q <= {sel_s_q[0], select_load_n};
    end
  end

  // Serial data, same depth as the clock so both stay aligned
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sdi_s_q <= 2'h0;
    end
    else if (clk_en)
    begin
      sdi_s_q <= {sdi_s_q[0], serial_in};
    end
  end

  // Async update, idles high
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      upd_s_q <= 2'h3;
    end
    else if (clk_en)
    begin
      upd_s_q <= {upd_s_q[0], async_update_n};
    end
  end

  // Async clear, idles high
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      clr_s_q <= 2'h3;
    end
    else if (clk_en)
    begin
      clr_s_q <= {clr_s_q[0], async_clear_n};
    end
  end

  // ****************************************
  // Edge detection
  // ****************************************
  reg sclk_d1_q;
  reg sel_d1_q;

  // History starts at the idle level so reset makes no false edge
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sclk_d1_q <= 1'b0;
    end
    else if (clk_en)
    begin
      sclk_d1_q <= sclk_s_q[1];
    end
  end

  // Select history
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sel_d1_q <= 1'b1;
    end
    else if (clk_en)
    begin
      sel_d1_q <= sel_s_q[1];
    end
  end

  wire sclk_rise = sclk_s_q[1] & ~sclk_d1_q;
  wire sclk_fall = ~sclk_s_q[1] & sclk_d1_q;
  wire sel_low   = ~sel_s_q[1];
  wire sel_rise  = sel_s_q[1] & ~sel_d1_q;
  wire upd_low   = ~upd_s_q[1];
  wire clr_low   = ~clr_s_q[1];

  // ****************************************
  // Shift register and data output
  // ****************************************
  reg [31:0] shift_q;

  // Bits enter only while selected
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      shift_q <= 32'h00000000;
    end
    else if (clk_en)
    begin
      if (sel_low && sclk_rise)
      begin
        shift_q <= {shift_q[30:0], sdi_s_q[1]};
      end
    end
  end

  // Chain output, always driven
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      serial_out <= 1'b0;
    end
    else if (clk_en)
    begin
      if (sclk_fall)
      begin
        serial_out <= shift_q[31];
      end
    end
  end

  // ****************************************
  // Command execution
  // ****************************************
  wire [3:0]  cmd_field = shift_q[`CMD_MSB:`CMD_LSB];
  wire [15:0] data_word = shift_q[`DATA_MSB:`DATA_LSB];
  wire        do_write  = cmd_writes(cmd_field);
  wire        do_update = cmd_updates(cmd_field);
  wire        do_pd     = cmd_sleeps(cmd_field);

  reg [15:0] next_input;
  reg        upd_seen_q;

  always @*
  begin
    next_input = (sel_rise && do_write) ? data_word : input_code;
  end

  // ****************************************
  // Input register
  // ****************************************
  // Power-down and other codes leave the old value in place
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      input_code <= RESET_CODE;
    end
    else if (clk_en)
    begin
      if (clr_low)
      begin
        input_code <= RESET_CODE;
      end
      else if (sel_rise)
      begin
        input_code <= next_input;
      end
    end
  end

  // ****************************************
  // DAC register
  // ****************************************
  // Async update acts once per falling level while deselected, and again at every select rise while held low
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      dac_code <= RESET_CODE;
    end
    else if (clk_en)
    begin
      if (clr_low)
      begin
        dac_code <= RESET_CODE;
      end
      else if (sel_rise)
      begin
        if (do_update || upd_low)
        begin
          dac_code <= next_input;
        end
      end
      else if (!sel_low && upd_low && !upd_seen_q)
      begin
        dac_code <= input_code;
      end
    end
  end

  // ****************************************
  // Async update history
  // ****************************************
  // A line held low loads only once while deselected, but a line already low when select rises loads again
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      upd_seen_q <= 1'b0;
    end
    else if (clk_en)
    begin
      upd_seen_q <= upd_low;
    end
  end

  // ****************************************
  // Power state
  // ****************************************
  // A low async line wins over a power-down command
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      powered_down <= 1'b0;
    end
    else if (clk_en)
    begin
      if (upd_low)
      begin
        powered_down <= 1'b0;
      end
      else if (sel_rise && do_update)
      begin
        powered_down <= 1'b0;
      end
      else if (sel_rise && do_pd)
      begin
        powered_down <= 1'b1;
      end
    end
  end

endmodule

// ### tb/dac_serial_if_chk.sv
// Assertion checker for the serial DAC interface
`timescale 1ns/1ps
module dac_serial_if_chk #(
  parameter MIDSCALE_RESET = 0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Pins
  input wire logic serial_clk,
  input wire logic select_load_n,
  input wire logic serial_out,
  input wire logic async_update_n,
  input wire logic async_clear_n,
  // Registers
  input wire logic [15:0] dac_code,
  input wire logic [15:0] input_code,
  input wire logic powered_down
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst || !clk_en);
  a_clear_zero: assert property (!async_clear_n |-> ##3 {dac_code, input_code} ==
    (MIDSCALE_RESET ? 32'h80008000 : 32'h0)) else $error("clear");
  a_update_power: assert property (!async_update_n [*3] |=> !powered_down)
    else $error("power");
  a_dac_source: assert property ($changed(dac_code) |-> dac_code == input_code)
    else $error("dac source");
  a_input_held: assert property ((!select_load_n && async_clear_n) [*4] |=> $stable(input_code))
    else $error("input held");
  a_dac_held: assert property ((!select_load_n && async_clear_n) [*4] |=> $stable(dac_code))
    else $error("dac held");
  a_pd_keeps: assert property ($rose(powered_down) |-> $stable(input_code) && $stable(dac_code))
    else $error("pd keeps");
  a_async_load: assert property ((select_load_n && async_clear_n) [*4] ##0 $fell(async_update_n)
    |-> ##3 dac_code == input_code && !powered_down) else $error("async load");
  a_out_lag: assert property ($changed(serial_out) |-> !$past(serial_clk, 3) && $past(serial_clk, 4))
    else $error("out lag");
  c_pd: cover property ($rose(powered_down));
  c_async: cover property (select_load_n && $fell(async_update_n));
  c_out: cover property ($changed(serial_out));
endmodule
bind dac_serial_if dac_serial_if_chk #(.MIDSCALE_RESET(MIDSCALE_RESET)) chk (.sys_clk, .sys_rst, .clk_en, .serial_clk,
  .select_load_n, .serial_out, .async_update_n, .async_clear_n, .dac_code, .input_code, .powered_down);

// ### tb/dac_host_model.sv
// Host serial controller model
`timescale 1ns/1ps
module dac_host_model (
  input wire logic sys_clk,
  output logic serial_clk,
  output logic select_load_n,
  output logic serial_in
);
  initial {serial_clk, select_load_n, serial_in} = 3'h2;
  task automatic wait_clk(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // One frame, MSB first; clock idles low and data flips once released
  task automatic send(input logic [31:0] w, input int n);
    select_load_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_in = w[i];
      wait_clk(4);
      serial_clk = 1'b1;
      wait_clk(4);
      serial_clk = 1'b0;
    end
    wait_clk(4);
    select_load_n = 1'b1;
    serial_in = ~serial_in;
    wait_clk(8);
  endtask
endmodule

// ### tb/serial_dac_command_interface_bench.sv
// Self-checking bench for the serial DAC interface
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fail_count++; $display("Error %s exp %h got %h", n, e, s); end end
module serial_dac_command_interface_bench;
  logic sys_clk = 0, sys_rst = 1, async_update_n = 1, async_clear_n = 1, e_pd = 0, clk_en = 1;
  wire serial_clk, select_load_n, serial_in, serial_out, powered_down, mid_out, mid_pd;
  wire [15:0] dac_code, input_code, mid_dac, mid_in;
  logic [15:0] e_in = 0, e_dac = 0;
  logic [31:0] sh = 0;
  int fail_count = 0, comparisons = 0, cycles = 0;
  logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'hF};
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  if (++cycles == 20000)
  begin
    fail_count++;
    conclude();
  end
  dac_host_model host (.sys_clk, .serial_clk, .select_load_n, .serial_in);
  dac_serial_if dut (.sys_clk, .sys_rst, .clk_en(clk_en), .serial_clk, .select_load_n, .serial_in, .serial_out,
    .async_update_n, .async_clear_n, .dac_code, .input_code, .powered_down);
  dac_serial_if #(.MIDSCALE_RESET(1)) dut_mid (.sys_clk, .sys_rst, .clk_en(1'b1), .serial_clk, .select_load_n,
    .serial_in, .serial_out(mid_out), .async_update_n, .async_clear_n, .dac_code(mid_dac), .input_code(mid_in),
    .powered_down(mid_pd));
  function automatic void predict(input logic [3:0] c, input logic [15:0] d);
    if (c == 4'h0 || c == 4'h3) e_in = d;
    if (c == 4'h1 || c == 4'h3 || !async_update_n) {e_dac, e_pd} = {e_in, 1'b0};
    else if (c == 4'h4) e_pd = 1'b1;
  endfunction
  task automatic run(input logic [3:0] c, input logic [15:0] d, input int n);
    logic [31:0] w;
    w = {8'($urandom()), c, 4'($urandom()), d};
    host.send(w, n);
    sh = n == 32 ? w : {sh[7:0], w[23:0]};
    predict(c, d);
    `CHK("input_code", e_in, input_code)
    `CHK("dac_code", e_dac, dac_code)
    `CHK("powered_down", e_pd, powered_down)
    `CHK("serial_out", sh[31], serial_out)
  endtask
  task automatic conclude();
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    void'($urandom(28));
    repeat (20) @(negedge sys_clk);
    sys_rst = 0;
    `CHK("mid_reset", 32'h80008000, {mid_dac, mid_in})
    foreach (codes[i]) run(codes[i], 16'hFFFF, 24);
    repeat (30) run(codes[$urandom() % 5], 16'($urandom()), $urandom() % 2 ? 32 : 24);
    async_update_n = 0;
    run(4'h0, 16'h0001, 24);
    run(4'h4, 16'h0002, 32);
    async_update_n = 1;
    run(4'h4, 16'h1234, 24);
    run(4'h0, 16'hA5A5, 24);
    async_update_n = 0;
    repeat (6) @(negedge sys_clk);
    async_update_n = 1;
    `CHK("async_dac", 16'hA5A5, dac_code)
    `CHK("async_pd", 1'b0, powered_down)
    clk_en = 0;
    async_clear_n = 0;
    repeat (6) @(negedge sys_clk);
    `CHK("frozen", 16'hA5A5, dac_code)
    clk_en = 1;
    repeat (6) @(negedge sys_clk);
    `CHK("clear", 32'h0, {dac_code, input_code})
    `CHK("mid_clear", 32'h80008000, {mid_dac, mid_in})
    conclude();
  end
endmodule
